// ### adc_pair_ctrl.sv
// Pair converter control: per-pair sample timing, pending queue, shared converter, registers
`timescale 1ns/1ps
`default_nettype none
module adc_pair_ctrl
    import adc_pair_pkg::*;
#(
    parameter int CLK_DIV = ADC_CLK_DIV
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [adc_pair_pkg::ADDR_W-1:0] addr,
    input wire logic [adc_pair_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [adc_pair_pkg::DATA_W-1:0] rdata,
    input wire logic [adc_pair_pkg::PAIRS-1:0] pwm_trigger,
    input wire logic [adc_pair_pkg::PAIRS-1:0] timer_trigger_source,
    input wire logic [adc_pair_pkg::PINS-1:0] pin_level,
    output logic [adc_pair_pkg::PINS-1:0] port_read_enable,
    output logic [adc_pair_pkg::PINS-1:0] mux_to_ground,
    output logic [adc_pair_pkg::PAIRS-1:0] sampling,
    output logic converting,
    output logic [3:0] convert_pair,
    output logic [adc_pair_pkg::PAIRS-1:0] pair_done,
    output logic pair_done_interrupt
);
    import adc_pair_pkg::*;

    typedef enum logic [1:0] {SH_IDLE, SH_SAMPLE, SH_PENDING} sh_state_e;
    typedef enum logic [0:0] {CV_IDLE, CV_BUSY} cv_state_e;

    function automatic logic [2:0] first_set(input logic [PAIRS-1:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = PAIRS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input logic strobe, input logic [3:0] a, input logic [3:0] off);
        return strobe && (a == off);
    endfunction

    logic [15:0] vector_base;
    logic [15:0] pin_analog_digital_config;
    logic [PAIRS-1:0] done_status;
    logic [PAIRS-1:0] done_enable;
    logic [15:0] vector_out;
    logic [RESULT_W-1:0] result_lo;
    logic [RESULT_W-1:0] result_hi;
    logic [2:0] last_pair;
    logic [7:0] div_cnt;
    logic adc_tick;
    logic [PAIRS-1:0] pwm_s1;
    logic [PAIRS-1:0] pwm_s2;
    logic [PAIRS-1:0] tmr_s1;
    logic [PAIRS-1:0] tmr_s2;
    logic [PAIRS-1:0] trig_now;
    logic [PAIRS-1:0] trig_s3;
    logic [PINS-1:0] pin_s1;
    logic [PINS-1:0] pin_s2;
    sh_state_e sh_state [PAIRS];
    logic [1:0] sh_cnt [PAIRS];
    logic [PAIRS-1:0] pending;
    logic [PAIRS-1:0] held_lo;
    logic [PAIRS-1:0] held_hi;
    cv_state_e cv_state;
    logic [4:0] cv_cnt;
    logic [2:0] cv_pair;
    logic [PAIRS-1:0] grant;
    logic [PAIRS-1:0] trig_rise;
    logic cv_finish;

    // Converter clock enable
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 8'h00;
            adc_tick <= 1'b0;
        end else if (div_cnt == 8'(CLK_DIV - 1)) begin
            div_cnt <= 8'h00;
            adc_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            adc_tick <= 1'b0;
        end
    end

    // Trigger synchronisers, one flop pair per source before they are merged
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_s1 <= '0;
            pwm_s2 <= '0;
        end else begin
            pwm_s1 <= pwm_trigger;
            pwm_s2 <= pwm_s1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_s1 <= '0;
            tmr_s2 <= '0;
        end else begin
            tmr_s1 <= timer_trigger_source;
            tmr_s2 <= tmr_s1;
        end
    end

    // Pin level synchroniser
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_level;
            pin_s2 <= pin_s1;
        end
    end

    // Edge detector; resets to the idle level so no false edge follows reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_s3 <= '0;
        end else begin
            trig_s3 <= trig_now;
        end
    end

    assign trig_now = pwm_s2 | tmr_s2;
    assign trig_rise = trig_now & ~trig_s3;
    assign cv_finish = (cv_state == CV_BUSY) && adc_tick && (cv_cnt == 5'(CONVERT_CYCLES - 1));
    assign grant = (cv_state == CV_IDLE) && (pending != '0) ? (PAIRS'(1) << first_set(pending)) : '0;

    // Per-pair sample and hold timing
    generate
        for (genvar p = 0; p < PAIRS; p++) begin : g_sh
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    sh_state[p] <= SH_IDLE;
                    sh_cnt[p] <= 2'h0;
                    pending[p] <= 1'b0;
                    held_lo[p] <= 1'b0;
                    held_hi[p] <= 1'b0;
                end else begin
                    unique case (sh_state[p])
                        SH_IDLE: begin
                            if (trig_rise[p]) begin
                                sh_state[p] <= SH_SAMPLE;
                                sh_cnt[p] <= 2'h0;
                            end
                        end
                        SH_SAMPLE: begin
                            if (adc_tick) begin
                                if (sh_cnt[p] == 2'(SAMPLE_CYCLES - 1)) begin
                                    // Analog pins give their level, digital pins give ground
                                    held_lo[p] <= pin_s2[2*p] & ~pin_analog_digital_config[2*p];
                                    held_hi[p] <= pin_s2[2*p+1] & ~pin_analog_digital_config[2*p+1];
                                    pending[p] <= 1'b1;
                                    sh_state[p] <= SH_PENDING;
                                end else begin
                                    sh_cnt[p] <= sh_cnt[p] + 2'h1;
                                end
                            end
                        end
                        SH_PENDING: begin
                            if (grant[p]) begin
                                pending[p] <= 1'b0;
                                sh_state[p] <= SH_IDLE;
                            end
                        end
                        default: sh_state[p] <= SH_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // Shared converter, one pair at a time
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cv_state <= CV_IDLE;
            cv_cnt <= 5'h00;
            cv_pair <= 3'h0;
        end else begin
            unique case (cv_state)
                CV_IDLE: begin
                    if (pending != '0) begin
                        cv_pair <= first_set(pending);
                        cv_cnt <= 5'h00;
                        cv_state <= CV_BUSY;
                    end
                end
                CV_BUSY: begin
                    if (cv_finish) begin
                        cv_state <= CV_IDLE;
                    end else if (adc_tick) begin
                        cv_cnt <= cv_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // Results of both channels of the pair land together
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            result_lo <= '0;
            result_hi <= '0;
            last_pair <= 3'h0;
        end else if (cv_finish) begin
            result_lo <= {RESULT_W{held_lo[cv_pair]}};
            result_hi <= {RESULT_W{held_hi[cv_pair]}};
            last_pair <= cv_pair;
        end
    end

    // One-cycle done pulse for the finished pair
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pair_done <= '0;
        end else begin
            pair_done <= '0;
            if (cv_finish) begin
                pair_done[cv_pair] <= 1'b1;
            end
        end
    end

    // Writable registers, one block each
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vector_base <= VECTOR_BASE_RESET;
        end else if (wr_hit(wr, addr, OFF_VECTOR_BASE)) begin
            vector_base <= wdata & VECTOR_BASE_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_analog_digital_config <= PIN_CONFIG_RESET;
        end else if (wr_hit(wr, addr, OFF_PIN_CONFIG)) begin
            pin_analog_digital_config <= wdata & PIN_CONFIG_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_enable <= '0;
        end else if (wr_hit(wr, addr, OFF_ENABLE)) begin
            done_enable <= wdata[PAIRS-1:0];
        end
    end

    // Sticky done flags: a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_status <= '0;
        end else begin
            done_status <= (done_status & ~(wr_hit(wr, addr, OFF_CLEAR) ? wdata[PAIRS-1:0] : '0))
                | (cv_finish ? (PAIRS'(1) << cv_pair) : '0);
        end
    end

    assign vector_out = vector_base + (16'(last_pair) << VECTOR_SHIFT);

    // Pin mode outputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port_read_enable <= '0;
            mux_to_ground <= '0;
        end else begin
            port_read_enable <= pin_analog_digital_config[PINS-1:0];
            mux_to_ground <= pin_analog_digital_config[PINS-1:0];
        end
    end

    // Sample phase flags, one per pair
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sampling <= '0;
        end else begin
            for (int i = 0; i < PAIRS; i++) begin
                sampling[i] <= (sh_state[i] == SH_SAMPLE);
            end
        end
    end

    // Converter status
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            converting <= 1'b0;
            convert_pair <= 4'h0;
        end else begin
            converting <= (cv_state == CV_BUSY);
            convert_pair <= {1'b0, cv_pair};
        end
    end

    // Level interrupt
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pair_done_interrupt <= 1'b0;
        end else begin
            pair_done_interrupt <= |(done_status & done_enable);
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                OFF_VECTOR_BASE: rdata <= vector_base;
                OFF_PIN_CONFIG: rdata <= pin_analog_digital_config;
                OFF_STATUS: rdata <= 16'(done_status);
                OFF_ENABLE: rdata <= 16'(done_enable);
                OFF_RESULT: rdata <= {3'h0, cv_state == CV_BUSY, 2'h0, result_hi[0], result_lo[0], 2'h0, pending};
                OFF_VECTOR: rdata <= {vector_out[15:2], 2'h0};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ### adc_pair_ctrl_checker.sv
// Port-level assertions for the pair converter control
`timescale 1ns/1ps
`default_nettype none
module adc_pair_ctrl_checker
    import adc_pair_pkg::*;
#(
    parameter int CLK_DIV = 2
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic [5:0] pwm_trigger,
    input wire logic [5:0] timer_trigger_source,
    input wire logic [11:0] port_read_enable,
    input wire logic [11:0] mux_to_ground,
    input wire logic [5:0] sampling,
    input wire logic converting,
    input wire logic [3:0] convert_pair,
    input wire logic [5:0] pair_done,
    input wire logic pair_done_interrupt
);
    logic [7:0] scnt;
    logic [7:0] ccnt;
    logic [3:0] cp_q;
    logic done_any;
    assign done_any = |pair_done;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Cycle counts of the pair 0 sample phase and of the current conversion
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scnt <= 8'h00;
            ccnt <= 8'h00;
            cp_q <= 4'h0;
        end else begin
            scnt <= sampling[0] ? scnt + 8'h01 : 8'h00;
            ccnt <= (converting && convert_pair == cp_q) ? ccnt + 8'h01 : {7'h00, converting};
            cp_q <= convert_pair;
        end
    end
    sequence trig0_s;
        $rose(pwm_trigger[0] | timer_trigger_source[0]) ##0 (sampling == 6'h00 && !converting);
    endsequence
    sequence conv_end_s;
        $fell(converting) or (converting && $past(converting) && convert_pair != cp_q);
    endsequence
    trig_start_a: assert property (trig0_s |-> ##[2:6] sampling[0])
        else $error("trigger did not start sampling");
    sample_len_a: assert property ($fell(sampling[0]) |-> scnt == SAMPLE_CYCLES * CLK_DIV)
        else $error("sample phase length wrong");
    post_req_a: assert property ($fell(sampling[0]) && !converting |-> ##[0:3] (converting && convert_pair == 4'h0))
        else $error("sampled pair not converted");
    pair_hold_a: assert property ($rose(converting) |=> $stable(convert_pair) [*8])
        else $error("converter pair changed early");
    convert_len_a: assert property (conv_end_s |-> ccnt == CONVERT_CYCLES * CLK_DIV)
        else $error("conversion length wrong");
    done_one_a: assert property (done_any |-> $onehot(pair_done) ##1 pair_done == 6'h00)
        else $error("done pulse not single pair");
    done_src_a: assert property (done_any |-> $past(converting) && pair_done == (6'h01 << $past(convert_pair)))
        else $error("done pulse for wrong pair");
    pin_mode_a: assert property (port_read_enable == mux_to_ground)
        else $error("pin read enable and ground select differ");
    rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read cycle");
    irq_cause_a: assert property ($rose(pair_done_interrupt) |-> done_any || $past(done_any) || $past(wr) || $past(wr, 2))
        else $error("interrupt rose without cause");
endmodule
bind adc_pair_ctrl adc_pair_ctrl_checker #(.CLK_DIV(CLK_DIV)) chk (.mclk, .rst_b, .wr, .rd, .rdata,
    .pwm_trigger, .timer_trigger_source, .port_read_enable, .mux_to_ground, .sampling, .converting,
    .convert_pair, .pair_done, .pair_done_interrupt);
`default_nettype wire

// ### adc_pair_pkg.sv
// Package with register map, field layout and timing constants of the pair converter control
package adc_pair_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PINS = 12;
    localparam int PAIRS = 6;
    localparam logic [3:0] OFF_VECTOR_BASE = 4'h0;
    localparam logic [3:0] OFF_PIN_CONFIG = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;
    localparam logic [3:0] OFF_CLEAR = 4'h3;
    localparam logic [3:0] OFF_ENABLE = 4'h4;
    localparam logic [3:0] OFF_RESULT = 4'h5;
    localparam logic [3:0] OFF_VECTOR = 4'h6;
    localparam logic [15:0] VECTOR_BASE_RESET = 16'h0000;
    localparam logic [15:0] VECTOR_BASE_MASK = 16'hfffe;
    localparam logic [15:0] PIN_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] PIN_CONFIG_MASK = 16'h0fff;
    localparam int VECTOR_SHIFT = 2;
    localparam int SAMPLE_CYCLES = 2;
    localparam int CONVERT_CYCLES = 24;
    localparam int ADC_CLK_DIV = 2;
    localparam int RESULT_W = 10;
endpackage

// ### pin_source_model.sv
// Far-side model: analog pin levels and stretched trigger requests
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
    input wire logic mclk,
    input wire logic [5:0] fire_pwm,
    input wire logic [5:0] fire_tmr,
    input wire logic [11:0] level,
    output logic [5:0] pwm_trigger,
    output logic [5:0] timer_trigger_source,
    output logic [11:0] pin_level
);
    logic [1:0] left;
    assign pin_level = level;
    initial begin
        pwm_trigger = 6'h00;
        timer_trigger_source = 6'h00;
        left = 2'h0;
    end
    // Hold each request long enough to pass the input synchronisers
    always @(posedge mclk) begin
        if (fire_pwm != 6'h00 || fire_tmr != 6'h00) begin
            pwm_trigger <= fire_pwm;
            timer_trigger_source <= fire_tmr;
            left <= 2'h3;
        end else if (left != 2'h0) begin
            left <= left - 2'h1;
        end else begin
            pwm_trigger <= 6'h00;
            timer_trigger_source <= 6'h00;
        end
    end
endmodule
`default_nettype wire

// ### test_adc_pair_ctrl.sv
// Testbench for the pair converter control
`timescale 1ns/1ps
`default_nettype none
module test_adc_pair_ctrl;
    import adc_pair_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] fire_pwm = 6'h00;
    logic [5:0] fire_tmr = 6'h00;
    logic [11:0] level = 12'hfff;
    logic [15:0] rdata;
    logic [5:0] pwm_t, tmr_t, sampling, pair_done;
    logic [11:0] pin_level, port_read_enable, mux_to_ground;
    logic converting, pair_done_interrupt;
    logic [3:0] convert_pair;
    int n_fail = 0;
    int compares = 0;
    pin_source_model far (.mclk(mclk), .fire_pwm(fire_pwm), .fire_tmr(fire_tmr), .level(level),
        .pwm_trigger(pwm_t), .timer_trigger_source(tmr_t), .pin_level(pin_level));
    adc_pair_ctrl #(.CLK_DIV(1)) dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pwm_trigger(pwm_t), .timer_trigger_source(tmr_t), .pin_level(pin_level),
        .port_read_enable(port_read_enable), .mux_to_ground(mux_to_ground), .sampling(sampling),
        .converting(converting), .convert_pair(convert_pair), .pair_done(pair_done),
        .pair_done_interrupt(pair_done_interrupt));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic fire(input logic [5:0] p, input logic [5:0] t);
        @(posedge mclk);
        fire_pwm <= p;
        fire_tmr <= t;
        @(posedge mclk);
        fire_pwm <= 6'h00;
        fire_tmr <= 6'h00;
    endtask
    task automatic wait_done(input logic [5:0] exp);
        int i;
        @(posedge mclk);
        #1;
        for (i = 0; i < 200 && pair_done === 6'h00; i++) begin
            @(posedge mclk);
            #1;
        end
        check({10'h000, pair_done}, {10'h000, exp});
    endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd_chk(OFF_VECTOR_BASE, VECTOR_BASE_RESET);
        rd_chk(OFF_PIN_CONFIG, PIN_CONFIG_RESET);
        rd_chk(4'hf, 16'h0000);
        wr_reg(OFF_VECTOR_BASE, 16'hffff);
        rd_chk(OFF_VECTOR_BASE, 16'hfffe);
        wr_reg(OFF_PIN_CONFIG, 16'hffff);
        rd_chk(OFF_PIN_CONFIG, 16'h0fff);
        check({4'h0, port_read_enable}, 16'h0fff);
        check({4'h0, mux_to_ground}, 16'h0fff);
        wr_reg(OFF_STATUS, 16'hffff);
        rd_chk(OFF_STATUS, 16'h0000);
        wr_reg(OFF_PIN_CONFIG, 16'h0001);
        wr_reg(OFF_VECTOR_BASE, 16'h0100);
        wr_reg(OFF_ENABLE, 16'h003f);
        fire(6'h01, 6'h00);
        repeat (4) @(posedge mclk);
        #1;
        check({10'h000, sampling}, 16'h0001);
        @(posedge mclk);
        #1;
        check({10'h000, sampling}, 16'h0001);
        @(posedge mclk);
        #1;
        check({10'h000, sampling}, 16'h0000);
        @(posedge mclk);
        #1;
        check({11'h000, converting, convert_pair}, 16'h0010);
        wait_done(6'h01);
        rd_chk(OFF_RESULT, 16'h0200);
        rd_chk(OFF_STATUS, 16'h0001);
        check({15'h0000, pair_done_interrupt}, 16'h0001);
        rd_chk(OFF_VECTOR, 16'h0100);
        wr_reg(OFF_CLEAR, 16'h0001);
        rd_chk(OFF_STATUS, 16'h0000);
        check({15'h0000, pair_done_interrupt}, 16'h0000);
        // Pair 3 waits behind pair 1 in the shared converter
        fire(6'h08, 6'h02);
        wait_done(6'h02);
        repeat (2) @(posedge mclk);
        #1;
        check({11'h000, converting, convert_pair}, 16'h0013);
        wait_done(6'h08);
        rd_chk(OFF_VECTOR, 16'h010c);
        rd_chk(OFF_RESULT, 16'h0300);
        rd_chk(OFF_STATUS, 16'h000a);
        wr_reg(OFF_CLEAR, 16'h003f);
        wr_reg(OFF_ENABLE, 16'h0000);
        fire(6'h20, 6'h00);
        wait_done(6'h20);
        rd_chk(OFF_STATUS, 16'h0020);
        check({15'h0000, pair_done_interrupt}, 16'h0000);
        wr_reg(OFF_ENABLE, 16'h0020);
        rd_chk(OFF_ENABLE, 16'h0020);
        check({15'h0000, pair_done_interrupt}, 16'h0001);
        stop_test();
    end
endmodule
`default_nettype wire
